// ==== msfu_defs.vh ====
`ifndef MSFU_DEFS_VH
`define MSFU_DEFS_VH

// clock and main scan timing
`define MSFU_CLK_PERIOD_NS 4
`define MSFU_SCAN_TIME_NS 1000000
`define MSFU_SCAN_CYCLES (`MSFU_SCAN_TIME_NS / `MSFU_CLK_PERIOD_NS)

// register byte offsets
`define MSFU_OFS_CTRL 8'h00
`define MSFU_OFS_FLAGS 8'h04
`define MSFU_OFS_IRQ_STATUS 8'h08
`define MSFU_OFS_IRQ_MASK 8'h0c
`define MSFU_OFS_DECEL_TIME 8'h10
`define MSFU_OFS_FEED_VALUE 8'h14
`define MSFU_OFS_WDT_CAUSE 8'h18
`define MSFU_OFS_TEST_INFO0 8'h1c
`define MSFU_OFS_TEST_INFO1 8'h20
`define MSFU_OFS_HW_INFO0 8'h24
`define MSFU_OFS_HW_INFO1 8'h28
`define MSFU_OFS_HW_INFO2 8'h2c

// control register fields
`define MSFU_CTRL_HOST_READY 0
`define MSFU_CTRL_SERVO_ON_REQ 1

// flag / irq layout
`define MSFU_FLAG_WDT 0
`define MSFU_FLAG_READY_DONE 1
`define MSFU_FLAG_TEST_ACTIVE 2
`define MSFU_FLAG_FORCED_STOP 3
`define MSFU_FLAG_HW_ERR 4
`define MSFU_FLAG_TEST_REQ_ERR 5
`define MSFU_FLAG_PROG_ERR 6
`define MSFU_FLAG_SERVO_ERR 7
`define MSFU_FLAG_W 8

// reset values
`define MSFU_RST_CTRL 2'h0
`define MSFU_RST_MASK 8'h00
`define MSFU_RST_DECEL 16'h000a
`define MSFU_RST_FLAGS 8'h00

`endif

// ==== msfu_scan_timer.v ====
`include "msfu_defs.vh"

// main scan cycle enable and scan counter
module msfu_scan_timer #(
  parameter SCAN_CYCLES = `MSFU_SCAN_CYCLES
) (
  input wire hclk,
  input wire hresetn,
  output reg scan_tick,
  output reg [15:0] scan_count
);
  reg [31:0] div_count;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_count <= 32'h00000000;
      scan_tick <= 1'b0;
      scan_count <= 16'h0000;
    end else if (div_count == SCAN_CYCLES - 1) begin
      div_count <= 32'h00000000;
      scan_tick <= 1'b1;
      scan_count <= scan_count + 16'h0001;
    end else begin
      div_count <= div_count + 32'h00000001;
      scan_tick <= 1'b0;
    end
  end
endmodule // msfu_scan_timer

// ==== msfu_status_unit.v ====
// The AHB-Lite register port and the register offsets were chosen for this implementation.
`include "msfu_defs.vh"

// What this block does
// RULE1: set processor watchdog error flag when self-diagnosis reports a watchdog error.
// RULE2: on watchdog error halt every axis at once, no deceleration. A forced stop in ST_DECEL still advances the feed value after axes_halt is set.
// RULE3: on watchdog error store the error cause in the cause word.
// RULE4: on host ready rising, check parameters; ready-done only if all clean.
// RULE5: ready sequence sends servo parameters to amplifiers and clears M-codes.
// RULE6: ready-done clears whenever host ready is low.
// RULE7: test request while test mode already active sets test request error.
// RULE8: forced stop while positioning keeps feed value advancing for deceleration time.
// RULE9: forced stop drops the all-axes servo-on command at once.
// RULE10: after deceleration time, feed value returns to value captured at stop.
// RULE11: forced stop released before deceleration time ends raises servo error.
// RULE12: handwheel axis setting error stores details in three info words.
// RULE13: test request error stores details in two info words.
// RULE14: program setting error flag low for normal data, high for abnormal.
// RULE15: host resets the processor after watchdog error; persisting flag means fault.
// RULE16: flags refresh once per main scan cycle; host only reads them. The servo error flag is also set in the clock cycle its condition appears.
// RULE17: after reset every flag stays low until its condition recurs.
module msfu_status_unit #(
  parameter SCAN_CYCLES = `MSFU_SCAN_CYCLES
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  output reg irq,
  input wire watchdog_error_detect,
  input wire [15:0] watchdog_cause_in,
  input wire fixed_param_error,
  input wire servo_param_error,
  input wire limit_output_data_error,
  input wire test_mode_request,
  input wire test_mode_cancel,
  input wire [15:0] test_request_code,
  input wire forced_stop_input,
  input wire positioning_active,
  input wire handwheel_setting_error,
  input wire [47:0] handwheel_error_detail,
  input wire motion_program_data_abnormal,
  output reg axes_halt,
  output reg all_axes_servo_on_command,
  output reg servo_param_transfer,
  output reg mcode_clear
);
  localparam ST_IDLE = 3'b001;
  localparam ST_DECEL = 3'b010;
  localparam ST_HOLD = 3'b100;
  localparam NSYNC = 9;

  // two-stage synchronisers for all pin inputs
  wire [NSYNC-1:0] pin_raw = {watchdog_error_detect, fixed_param_error, servo_param_error,
    limit_output_data_error, test_mode_request, test_mode_cancel, forced_stop_input,
    handwheel_setting_error, motion_program_data_abnormal};
  reg [NSYNC-1:0] pin_meta;
  reg [NSYNC-1:0] pin_sync;
  reg [15:0] cause_meta;
  reg [15:0] cause_sync;
  reg [15:0] code_meta;
  reg [15:0] code_sync;
  reg [47:0] hw_meta;
  reg [47:0] hw_sync;
  reg pos_meta;
  reg pos_sync;
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cause_meta <= 16'h0000;
      cause_sync <= 16'h0000;
      code_meta <= 16'h0000;
      code_sync <= 16'h0000;
      hw_meta <= 48'h000000000000;
      hw_sync <= 48'h000000000000;
      pos_meta <= 1'b0;
      pos_sync <= 1'b0;
    end else begin
      cause_meta <= watchdog_cause_in;
      cause_sync <= cause_meta;
      code_meta <= test_request_code;
      code_sync <= code_meta;
      hw_meta <= handwheel_error_detail;
      hw_sync <= hw_meta;
      pos_meta <= positioning_active;
      pos_sync <= pos_meta;
    end
  end

  wire wdt_s = pin_sync[8];
  wire param_bad = pin_sync[7] | pin_sync[6] | pin_sync[5];
  wire test_req_s = pin_sync[4];
  wire test_cancel_s = pin_sync[3];
  wire fstop_s = pin_sync[2];
  wire hw_err_s = pin_sync[1];
  wire prog_bad_s = pin_sync[0];

  wire scan_tick;
  wire [15:0] scan_count;
  msfu_scan_timer #(.SCAN_CYCLES(SCAN_CYCLES)) u_scan (
    .hclk(hclk),
    .hresetn(hresetn),
    .scan_tick(scan_tick),
    .scan_count(scan_count)
  );

  // registers
  reg [1:0] ctrl;
  reg [`MSFU_FLAG_W-1:0] flags;
  reg [`MSFU_FLAG_W-1:0] irq_status;
  reg [`MSFU_FLAG_W-1:0] irq_mask;
  reg [15:0] decel_time;
  reg [31:0] feed_value;
  reg [31:0] feed_capture;
  reg [15:0] decel_count;
  reg [2:0] stop_state;
  reg [15:0] wdt_cause;
  reg [15:0] test_info0;
  reg [15:0] test_info1;
  reg [47:0] hw_info;
  reg host_ready_seen;
  reg fstop_prev;
  reg test_req_prev;
  reg test_cancel_prev;
  reg test_req_pend;
  reg test_cancel_pend;

  // ahb-lite data phase bookkeeping
  reg dp_write;
  reg [7:0] dp_addr;
  wire ap_valid = hsel & hready & htrans[1];
  wire wr_ctrl = dp_write && dp_addr == `MSFU_OFS_CTRL;
  wire wr_irqs = dp_write && dp_addr == `MSFU_OFS_IRQ_STATUS;
  wire wr_mask = dp_write && dp_addr == `MSFU_OFS_IRQ_MASK;
  wire wr_decel = dp_write && dp_addr == `MSFU_OFS_DECEL_TIME;

  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h00000000;
    case (haddr[7:0])
      `MSFU_OFS_CTRL: next_rdata = {30'h00000000, ctrl};
      `MSFU_OFS_FLAGS: next_rdata = {24'h000000, flags};
      `MSFU_OFS_IRQ_STATUS: next_rdata = {24'h000000, irq_status};
      `MSFU_OFS_IRQ_MASK: next_rdata = {24'h000000, irq_mask};
      `MSFU_OFS_DECEL_TIME: next_rdata = {16'h0000, decel_time};
      `MSFU_OFS_FEED_VALUE: next_rdata = feed_value;
      `MSFU_OFS_WDT_CAUSE: next_rdata = {16'h0000, wdt_cause};
      `MSFU_OFS_TEST_INFO0: next_rdata = {16'h0000, test_info0};
      `MSFU_OFS_TEST_INFO1: next_rdata = {16'h0000, test_info1};
      `MSFU_OFS_HW_INFO0: next_rdata = {16'h0000, hw_info[15:0]};
      `MSFU_OFS_HW_INFO1: next_rdata = {16'h0000, hw_info[31:16]};
      `MSFU_OFS_HW_INFO2: next_rdata = {16'h0000, hw_info[47:32]};
      default: next_rdata = 32'h00000000;
    endcase
    if (haddr[31:8] != 24'h000000) begin
      next_rdata = 32'h00000000;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      dp_write <= ap_valid & hwrite & (haddr[31:8] == 24'h000000);
      dp_addr <= haddr[7:0];
      if (ap_valid & ~hwrite) begin
        hrdata <= next_rdata; // [RULE16]
      end
    end
  end

  // software-written registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `MSFU_RST_CTRL;
      irq_mask <= `MSFU_RST_MASK;
      decel_time <= `MSFU_RST_DECEL;
    end else begin
      if (wr_ctrl) begin
        ctrl <= hwdata[1:0];
      end
      if (wr_mask) begin
        irq_mask <= hwdata[`MSFU_FLAG_W-1:0];
      end
      if (wr_decel) begin
        decel_time <= hwdata[15:0];
      end
    end
  end

  wire host_ready = ctrl[`MSFU_CTRL_HOST_READY];
  wire decel_done = stop_state == ST_DECEL && scan_tick && decel_count <= 16'h0001;

  // forced stop sequencing and feed value
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stop_state <= ST_IDLE;
      feed_value <= 32'h00000000;
      feed_capture <= 32'h00000000;
      decel_count <= 16'h0000;
      fstop_prev <= 1'b0;
    end else begin
      fstop_prev <= fstop_s;
      case (stop_state)
        ST_IDLE: begin
          if (fstop_s & ~fstop_prev & pos_sync) begin
            feed_capture <= feed_value;
            decel_count <= decel_time;
            stop_state <= ST_DECEL;
          end else if (scan_tick & pos_sync & ~axes_halt) begin
            feed_value <= feed_value + 32'h00000001;
          end
        end
        ST_DECEL: begin
          if (!fstop_s) begin
            stop_state <= ST_IDLE;
          end else if (decel_done) begin
            feed_value <= feed_capture; // [RULE10]
            stop_state <= ST_HOLD;
          end else if (scan_tick) begin
            feed_value <= feed_value + 32'h00000001; // [RULE8]
            decel_count <= decel_count - 16'h0001;
          end
        end
        ST_HOLD: begin
          if (!fstop_s) begin
            stop_state <= ST_IDLE;
          end
        end
        default: stop_state <= ST_IDLE;
      endcase
    end
  end

  // immediate axis commands
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      axes_halt <= 1'b0;
      all_axes_servo_on_command <= 1'b0;
    end else begin
      if (wdt_s) begin
        axes_halt <= 1'b1; // [RULE2]
      end
      all_axes_servo_on_command <= ctrl[`MSFU_CTRL_SERVO_ON_REQ] & ~fstop_s & ~wdt_s & ~axes_halt; // [RULE9]
    end
  end

  // test mode request and cancel edges held until the next scan
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      test_req_prev <= 1'b0;
      test_cancel_prev <= 1'b0;
      test_req_pend <= 1'b0;
      test_cancel_pend <= 1'b0;
    end else begin
      test_req_prev <= test_req_s;
      test_cancel_prev <= test_cancel_s;
      if (test_req_s & ~test_req_prev) begin
        test_req_pend <= 1'b1;
      end else if (scan_tick) begin
        test_req_pend <= 1'b0;
      end
      if (test_cancel_s & ~test_cancel_prev) begin
        test_cancel_pend <= 1'b1;
      end else if (scan_tick) begin
        test_cancel_pend <= 1'b0;
      end
    end
  end

  // scan-cycle flag refresh
  reg [`MSFU_FLAG_W-1:0] next_flags;
  reg ready_rise;
  always @* begin
    next_flags = flags;
    ready_rise = host_ready & ~host_ready_seen;
    if (wdt_s) begin
      next_flags[`MSFU_FLAG_WDT] = 1'b1; // [RULE1]
    end
    if (!host_ready) begin
      next_flags[`MSFU_FLAG_READY_DONE] = 1'b0; // [RULE6]
    end else if (ready_rise) begin
      next_flags[`MSFU_FLAG_READY_DONE] = ~param_bad; // [RULE4]
    end
    if (test_req_pend & flags[`MSFU_FLAG_TEST_ACTIVE]) begin
      next_flags[`MSFU_FLAG_TEST_REQ_ERR] = 1'b1; // [RULE7]
    end else if (test_req_pend) begin
      next_flags[`MSFU_FLAG_TEST_ACTIVE] = 1'b1;
    end else if (test_cancel_pend) begin
      next_flags[`MSFU_FLAG_TEST_ACTIVE] = 1'b0;
      next_flags[`MSFU_FLAG_TEST_REQ_ERR] = 1'b0;
    end
    next_flags[`MSFU_FLAG_FORCED_STOP] = fstop_s;
    next_flags[`MSFU_FLAG_HW_ERR] = hw_err_s;
    next_flags[`MSFU_FLAG_PROG_ERR] = prog_bad_s; // [RULE14]
    if (ready_rise) begin
      next_flags[`MSFU_FLAG_SERVO_ERR] = 1'b0;
    end
    if (stop_state == ST_DECEL && !fstop_s) begin
      next_flags[`MSFU_FLAG_SERVO_ERR] = 1'b1; // [RULE11]
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags <= `MSFU_RST_FLAGS; // [RULE17]
      host_ready_seen <= 1'b0;
      wdt_cause <= 16'h0000;
      test_info0 <= 16'h0000;
      test_info1 <= 16'h0000;
      hw_info <= 48'h000000000000;
      servo_param_transfer <= 1'b0;
      mcode_clear <= 1'b0;
    end else begin
      servo_param_transfer <= 1'b0;
      mcode_clear <= 1'b0;
      if (stop_state == ST_DECEL && !fstop_s) begin
        flags[`MSFU_FLAG_SERVO_ERR] <= 1'b1; // [RULE11]
      end
      if (scan_tick) begin
        flags <= next_flags; // [RULE16]
        host_ready_seen <= host_ready;
        if (ready_rise & ~param_bad) begin
          servo_param_transfer <= 1'b1; // [RULE5]
          mcode_clear <= 1'b1; // [RULE5]
        end
        if (next_flags[`MSFU_FLAG_WDT] & ~flags[`MSFU_FLAG_WDT]) begin
          wdt_cause <= cause_sync; // [RULE3]
        end
        if (next_flags[`MSFU_FLAG_TEST_REQ_ERR] & ~flags[`MSFU_FLAG_TEST_REQ_ERR]) begin
          test_info0 <= code_sync; // [RULE13]
          test_info1 <= scan_count; // [RULE13]
        end
        if (next_flags[`MSFU_FLAG_HW_ERR]) begin
          hw_info <= hw_sync; // [RULE12]
        end
      end
    end
  end

  // sticky events on flag rising edges; set wins over write-one clear
  reg [`MSFU_FLAG_W-1:0] flags_prev;
  wire [`MSFU_FLAG_W-1:0] flag_rise = flags & ~flags_prev;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_prev <= `MSFU_RST_FLAGS;
      irq_status <= `MSFU_RST_FLAGS;
      irq <= 1'b0;
    end else begin
      flags_prev <= flags;
      irq_status <= (irq_status & ~(wr_irqs ? hwdata[`MSFU_FLAG_W-1:0] : `MSFU_RST_FLAGS)) | flag_rise;
      irq <= |(irq_status & irq_mask);
    end
  end
endmodule // msfu_status_unit

// ==== msfu_status_sva.sv ====
module msfu_status_sva #(
  parameter SCAN_CYCLES = 16
) (
  input wire hclk,
  input wire hresetn,
  input wire hreadyout,
  input wire hresp,
  input wire irq,
  input wire watchdog_error_detect,
  input wire fixed_param_error,
  input wire servo_param_error,
  input wire limit_output_data_error,
  input wire forced_stop_input,
  input wire axes_halt,
  input wire all_axes_servo_on_command,
  input wire servo_param_transfer,
  input wire mcode_clear
);
  int cnt;
  // cycles since reset, saturating at the first scan tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cnt <= 0;
    else if (cnt < SCAN_CYCLES) cnt <= cnt + 1;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_wdt; watchdog_error_detect [*3]; endsequence
  sequence s_fstop; forced_stop_input [*6]; endsequence
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus answer not ready okay");
  property p_wdt_halt; s_wdt |-> ##[0:4] axes_halt; endproperty
  a_wdt_halt: assert property (p_wdt_halt) else $error("axes not halted after watchdog");
  property p_halt_hold; axes_halt |=> axes_halt; endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt dropped before reset");
  property p_halt_servo; axes_halt |=> !all_axes_servo_on_command; endproperty
  a_halt_servo: assert property (p_halt_servo) else $error("servo on while halted");
  property p_fstop; s_fstop |-> !all_axes_servo_on_command; endproperty
  a_fstop: assert property (p_fstop) else $error("servo on during forced stop");
  property p_pulse; servo_param_transfer |=> !servo_param_transfer && !mcode_clear; endproperty
  a_pulse: assert property (p_pulse) else $error("transfer pulse too long");
  property p_pair; servo_param_transfer == mcode_clear; endproperty
  a_pair: assert property (p_pair) else $error("transfer and code clear apart");
  property p_ready_check;
    servo_param_transfer |-> !$past(fixed_param_error, 5) && !$past(servo_param_error, 5)
      && !$past(limit_output_data_error, 5);
  endproperty
  a_ready_check: assert property (p_ready_check) else $error("transfer despite check error");
  property p_quiet; cnt < SCAN_CYCLES |-> !irq && !servo_param_transfer && !mcode_clear; endproperty
  a_quiet: assert property (p_quiet) else $error("activity before first scan");
endmodule // msfu_status_sva

bind msfu_status_unit msfu_status_sva #(.SCAN_CYCLES(SCAN_CYCLES)) u_sva (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
  .watchdog_error_detect(watchdog_error_detect), .fixed_param_error(fixed_param_error),
  .servo_param_error(servo_param_error), .limit_output_data_error(limit_output_data_error),
  .forced_stop_input(forced_stop_input), .axes_halt(axes_halt),
  .all_axes_servo_on_command(all_axes_servo_on_command),
  .servo_param_transfer(servo_param_transfer), .mcode_clear(mcode_clear)
);

// ==== msfu_test_tool_model.sv ====
module msfu_test_tool_model (
  input wire hclk,
  output logic test_mode_request,
  output logic test_mode_cancel,
  output logic [15:0] test_request_code
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    test_mode_request = 1'b0;
    test_mode_cancel = 1'b0;
    test_request_code = 16'h0;
  end
  // request or cancel as a rising edge held a few cycles
  task automatic pulse(input logic cancel, input logic [15:0] code);
    @(posedge hclk);
    test_request_code <= code;
    test_mode_request <= !cancel;
    test_mode_cancel <= cancel;
    repeat (6) @(posedge hclk);
    test_mode_request <= 1'b0;
    test_mode_cancel <= 1'b0;
  endtask
endmodule // msfu_test_tool_model

// ==== motion_status_flag_unit_test.sv ====
`include "msfu_defs.vh"

module motion_status_flag_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SCAN = 16;
  localparam int SP = 4 * SCAN;
  localparam logic [31:0] ALL = 32'hffffffff;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic wdt = 1'b0;
  logic [15:0] cause = 16'h0;
  logic [2:0] perr = 3'h0;
  logic fstop = 1'b0;
  logic pos = 1'b0;
  logic hw_err = 1'b0;
  logic [47:0] detail = 48'h0;
  logic prog_bad = 1'b0;
  logic [31:0] hrdata, f0, d;
  logic hreadyout, hresp, irq, halt, servo_on, xfer, mclr, treq, tcan;
  logic [15:0] tcode;
  int n_fail = 0;
  int n_checks = 0;
  int n_xfer = 0;

  msfu_status_unit #(.SCAN_CYCLES(SCAN)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq), .watchdog_error_detect(wdt), .watchdog_cause_in(cause),
    .fixed_param_error(perr[0]), .servo_param_error(perr[1]), .limit_output_data_error(perr[2]),
    .test_mode_request(treq), .test_mode_cancel(tcan), .test_request_code(tcode),
    .forced_stop_input(fstop), .positioning_active(pos), .handwheel_setting_error(hw_err),
    .handwheel_error_detail(detail), .motion_program_data_abnormal(prog_bad), .axes_halt(halt),
    .all_axes_servo_on_command(servo_on), .servo_param_transfer(xfer), .mcode_clear(mclr)
  );
  msfu_test_tool_model u_tool (
    .hclk(hclk), .test_mode_request(treq), .test_mode_cancel(tcan), .test_request_code(tcode)
  );

  initial forever #2 hclk = ~hclk;
  always @(posedge hclk) if (xfer === 1'b1) n_xfer++;

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t ns: seen %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_fail++;
      $display("Error at %0t ns: bus wait timed out", $time);
      finish_test();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    d = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bus(1'b1, a, v);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(d & m, e);
  endtask

  initial begin
    cyc(10);
    hresetn <= 1'b1;
    cyc(1);
    rd(`MSFU_OFS_CTRL, ALL, 32'h0);
    rd(`MSFU_OFS_FLAGS, ALL, 32'h0);
    rd(`MSFU_OFS_DECEL_TIME, ALL, 32'ha);
    wr(`MSFU_OFS_FLAGS, 32'hff);
    rd(`MSFU_OFS_FLAGS, ALL, 32'h0);
    rd(8'h30, ALL, 32'h0);
    wr(`MSFU_OFS_IRQ_MASK, 32'hff);
    wr(`MSFU_OFS_CTRL, 32'h3);
    cyc(SP);
    rd(`MSFU_OFS_FLAGS, ALL, 32'h2);
    check({31'h0, irq}, 32'h1);
    check(n_xfer, 32'h1);
    rd(`MSFU_OFS_IRQ_STATUS, ALL, 32'h2);
    wr(`MSFU_OFS_IRQ_STATUS, 32'h2);
    cyc(2);
    check({31'h0, irq}, 32'h0);
    wr(`MSFU_OFS_CTRL, 32'h2);
    cyc(SP);
    rd(`MSFU_OFS_FLAGS, ALL, 32'h0);
    for (int i = 0; i < 3; i++) begin
      perr <= 3'h1 << i;
      cyc(4);
      wr(`MSFU_OFS_CTRL, 32'h3);
      cyc(SP);
      rd(`MSFU_OFS_FLAGS, ALL, 32'h0);
      wr(`MSFU_OFS_CTRL, 32'h2);
      perr <= 3'h0;
      cyc(SP);
    end
    check(n_xfer, 32'h1);
    prog_bad <= 1'b1;
    cyc(SP);
    rd(`MSFU_OFS_FLAGS, ALL, 32'h40);
    prog_bad <= 1'b0;
    cyc(SP);
    rd(`MSFU_OFS_FLAGS, ALL, 32'h0);
    u_tool.pulse(1'b0, 16'h0123);
    cyc(SP);
    u_tool.pulse(1'b0, 16'h0456);
    cyc(SP);
    rd(`MSFU_OFS_FLAGS, ALL, 32'h24);
    rd(`MSFU_OFS_TEST_INFO0, ALL, 32'h456);
    u_tool.pulse(1'b1, 16'h0);
    cyc(SP);
    rd(`MSFU_OFS_FLAGS, ALL, 32'h0);
    hw_err <= 1'b1;
    detail <= 48'h333322221111;
    cyc(SP);
    rd(`MSFU_OFS_FLAGS, ALL, 32'h10);
    for (int i = 0; i < 3; i++) rd(`MSFU_OFS_HW_INFO0 + 8'(4 * i), ALL, {16'h0, detail[16*i+:16]});
    hw_err <= 1'b0;
    wr(`MSFU_OFS_DECEL_TIME, 32'h4);
    cyc(SP);
    bus(1'b0, `MSFU_OFS_FEED_VALUE, 32'h0);
    f0 = d;
    check({31'h0, servo_on}, 32'h1);
    pos <= 1'b1;
    fstop <= 1'b1;
    cyc(8);
    check({31'h0, servo_on}, 32'h0);
    cyc(32);
    rd(`MSFU_OFS_FLAGS, 32'h8, 32'h8);
    bus(1'b0, `MSFU_OFS_FEED_VALUE, 32'h0);
    check({31'h0, d > f0}, 32'h1);
    cyc(SP);
    rd(`MSFU_OFS_FEED_VALUE, ALL, f0);
    fstop <= 1'b0;
    cyc(SP);
    fstop <= 1'b1;
    cyc(24);
    fstop <= 1'b0;
    cyc(32);
    rd(`MSFU_OFS_FLAGS, 32'h80, 32'h80);
    cause <= 16'h00a5;
    wdt <= 1'b1;
    cyc(8);
    check({31'h0, halt}, 32'h1);
    check({31'h0, servo_on}, 32'h0);
    cyc(SP);
    rd(`MSFU_OFS_FLAGS, 32'h1, 32'h1);
    rd(`MSFU_OFS_WDT_CAUSE, ALL, 32'ha5);
    wdt <= 1'b0;
    hresetn <= 1'b0;
    cyc(10);
    hresetn <= 1'b1;
    cyc(2);
    check({30'h0, halt, irq}, 32'h0);
    rd(`MSFU_OFS_FLAGS, ALL, 32'h0);
    finish_test();
  end
endmodule // motion_status_flag_unit_test
